/* slg_defs.svh */
// constants for the scan logic gate bank: operand codes, sizes and reset values
`ifndef SLG_DEFS_SVH
`define SLG_DEFS_SVH

// number of gate slots in the bank
`define SLG_NUM_GATES      8
// physical input space: 14 base inputs plus 12 for each of 3 extension modules
`define SLG_BASE_INPUTS    14
`define SLG_EXT_INPUTS     12
`define SLG_EXT_MODULES    3
`define SLG_PHYS_INPUTS    50
`define SLG_VKEYS          32
// output space: 8 base outputs plus 8 for each extension module
`define SLG_BASE_OUTS      8
`define SLG_EXT_OUTS       8
`define SLG_ALL_OUTS       32
`define SLG_OUT_IDX_W      5
// operand selector encoding (8 bits)
`define SLG_SEL_W          8
`define SLG_SEL_PHYS_LAST  8'h31
`define SLG_SEL_VKEY_FIRST 8'h40
`define SLG_SEL_VKEY_LAST  8'h5F
`define SLG_SEL_HIGH       8'h60
`define SLG_SEL_LOW        8'h61
`define SLG_SEL_NOCONN     8'h7F
// reset values
`define SLG_OUTS_RST       32'h0000_0000
`define SLG_HIST_RST       4'h0

`endif

/* slg_pkg.sv */
// types of the scan logic gate bank
package slg_pkg;
  `include "slg_defs.svh"

  // gate function of one slot
  typedef enum logic [2:0] {
    SLG_AND      = 3'h0,
    SLG_AND_EDGE = 3'h1,
    SLG_OR       = 3'h2,
    SLG_NOT      = 3'h3,
    SLG_XOR      = 3'h4,
    SLG_NAND     = 3'h5,
    SLG_NAND_EDG = 3'h6,
    SLG_NOR      = 3'h7
  } slg_kind_t;

  // configuration of one gate slot
  typedef struct packed {
    slg_kind_t                  kind;
    logic [`SLG_SEL_W-1:0]      gateInFirst;
    logic [`SLG_SEL_W-1:0]      gateInSecond;
    logic [`SLG_SEL_W-1:0]      gateInThird;
    logic [`SLG_SEL_W-1:0]      gateInFourth;
    logic                       destEn;
    logic [`SLG_OUT_IDX_W-1:0]  destIdx;
  } slg_cfg_t;

  // operand sources sampled by the bank
  typedef struct packed {
    logic [`SLG_PHYS_INPUTS-1:0] physIn;
    logic [`SLG_VKEYS-1:0]       virtualKeySources;
  } slg_src_t;

  // whole state of the bank
  typedef struct packed {
    logic [`SLG_ALL_OUTS-1:0]              outs;
    logic [`SLG_NUM_GATES-1:0][3:0]        priorPeriodEdgeQualifier;
    logic [`SLG_NUM_GATES-1:0]             result;
    logic                                  scanDone;
  } slg_state_t;

endpackage : slg_pkg

/* slg_gate_bank.sv */
// scan-evaluated bank of general logic gates driving the output image
`timescale 1ns/1ps
`include "slg_defs.svh"
// Notes on behaviour
// - AND outputs 1 only when all four are 1
// - edge AND: all 1 now, some 0 before
// - edge AND: unconnected input counts as 1
// - OR outputs 1 when any input is 1
// - NOT inverts its single input
// - XOR outputs 1 when two inputs differ
// - NAND outputs 0 only when all are 1
// - edge NAND: some 0 now, all 1 before
// - edge NAND: unconnected input counts as 1
// - NOR outputs 1 only when all are 0
// - operands may be high, low or unconnected
// - operand space holds thirty-two virtual keys
// - eight base plus eight per extension outputs
module slg_gate_bank (
  // clock and reset
  input  wire logic                                 clk_sys,
  input  wire logic                                 rst_n,
  // scan period strobe
  input  wire logic                                 scanTick,
  // operand sources
  input  wire slg_pkg::slg_src_t                    src,
  // gate slot configuration, slot 0 is executed first
  input  wire slg_pkg::slg_cfg_t [`SLG_NUM_GATES-1:0] cfg,
  // output image
  output logic [`SLG_BASE_OUTS-1:0]                 baseOutputs,
  output logic [`SLG_EXT_MODULES*`SLG_EXT_OUTS-1:0] extOutputs,
  // per-slot results and scan completion
  output logic [`SLG_NUM_GATES-1:0]                 gateResult,
  output logic                                      scanDone
);
  import slg_pkg::*;

  slg_state_t state_ff;
  slg_state_t nxt_state;

  // fetch one operand; ncVal is the level an unconnected input takes
  function automatic logic fetchOperand(
    input logic [`SLG_SEL_W-1:0] sel,
    input slg_src_t              s,
    input logic                  ncVal
  );
    logic bit_v;
    bit_v = 1'b0;
    if (sel <= `SLG_SEL_PHYS_LAST) begin
      bit_v = s.physIn[sel[5:0]];
    end else if (sel >= `SLG_SEL_VKEY_FIRST && sel <= `SLG_SEL_VKEY_LAST) begin
      bit_v = s.virtualKeySources[sel[4:0]];
    end else if (sel == `SLG_SEL_HIGH) begin
      bit_v = 1'b1;
    end else if (sel == `SLG_SEL_LOW) begin
      bit_v = 1'b0;
    end else if (sel == `SLG_SEL_NOCONN) begin
      // no connection takes the neutral level
      bit_v = ncVal;
    end else begin
      // undefined codes read as low
      bit_v = 1'b0;
    end
    return bit_v;
  endfunction : fetchOperand

  // level an unconnected input takes for a given gate kind
  function automatic logic neutralLevel(input slg_kind_t k);
    logic lvl;
    lvl = 1'b0;
    case (k)
      // conjunction family ignores open inputs as 1
      SLG_AND,
      SLG_NAND:     lvl = 1'b1;
      // open input of edge AND is 1
      SLG_AND_EDGE: lvl = 1'b1;
      // open input of edge NAND is 1
      SLG_NAND_EDG: lvl = 1'b1;
      // disjunction family ignores open inputs as 0
      SLG_OR,
      SLG_NOR:      lvl = 1'b0;
      default:      lvl = 1'b0;
    endcase
    return lvl;
  endfunction : neutralLevel

  // gate result from the current and prior operand vectors
  function automatic logic evalGate(
    input slg_kind_t  k,
    input logic [3:0] cur,
    input logic [3:0] prior
  );
    logic q;
    q = 1'b0;
    case (k)
      SLG_AND:      q = &cur;
      // all high now, at least one low last period
      SLG_AND_EDGE: q = (&cur) && !(&prior);
      SLG_OR:       q = |cur;
      // inverter uses the first input only
      SLG_NOT:      q = ~cur[0];
      // exclusive gate on the first two inputs
      SLG_XOR:      q = cur[0] ^ cur[1];
      SLG_NAND:     q = ~(&cur);
      // some low now, all high last period
      SLG_NAND_EDG: q = !(&cur) && (&prior);
      SLG_NOR:      q = ~(|cur);
      default:      q = 1'b0;
    endcase
    return q;
  endfunction : evalGate

  // one scan: evaluate slots in order, later slots win a shared output
  always_comb begin
    logic [3:0] curIn;
    logic       nc;
    logic       q;
    curIn = 4'h0;
    nc = 1'b0;
    q = 1'b0;
    nxt_state = state_ff;
    nxt_state.scanDone = 1'b0;
    // gates only advance on the scan tick
    if (scanTick) begin
      nxt_state.scanDone = 1'b1;
      for (int g = 0; g < `SLG_NUM_GATES; g++) begin
        nc = neutralLevel(cfg[g].kind);
        curIn[0] = fetchOperand(cfg[g].gateInFirst, src, nc);
        curIn[1] = fetchOperand(cfg[g].gateInSecond, src, nc);
        curIn[2] = fetchOperand(cfg[g].gateInThird, src, nc);
        curIn[3] = fetchOperand(cfg[g].gateInFourth, src, nc);
        q = evalGate(cfg[g].kind, curIn, state_ff.priorPeriodEdgeQualifier[g]);
        nxt_state.result[g] = q;
        // keep this period's vector for the next
        nxt_state.priorPeriodEdgeQualifier[g] = curIn;
        // write into the 32-bit output image
        if (cfg[g].destEn) begin
          nxt_state.outs[cfg[g].destIdx] = q;
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff.outs <= `SLG_OUTS_RST;
      for (int g = 0; g < `SLG_NUM_GATES; g++) begin
        state_ff.priorPeriodEdgeQualifier[g] <= `SLG_HIST_RST;
      end
      state_ff.result <= '0;
      state_ff.scanDone <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // output image split into base and extension groups
  assign baseOutputs = state_ff.outs[`SLG_BASE_OUTS-1:0];
  assign extOutputs  = state_ff.outs[`SLG_ALL_OUTS-1:`SLG_BASE_OUTS];
  assign gateResult  = state_ff.result;
  assign scanDone    = state_ff.scanDone;

endmodule : slg_gate_bank

/* slg_gate_bank_asserts.sv */
// assertion checker for the scan logic gate bank
`timescale 1ns/1ps
`include "slg_defs.svh"
module slg_gate_bank_asserts (
  // clock and reset
  input wire logic                                 clk_sys,
  input wire logic                                 rst_n,
  // bank inputs
  input wire logic                                 scanTick,
  input wire slg_pkg::slg_src_t                    src,
  input wire slg_pkg::slg_cfg_t [`SLG_NUM_GATES-1:0] cfg,
  // bank outputs
  input wire logic [7:0]                           baseOutputs,
  input wire logic [23:0]                          extOutputs,
  input wire logic [7:0]                           gateResult,
  input wire logic                                 scanDone
);
  import slg_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // slot 0 wired straight to physical inputs 0..3
  wire logic [3:0] x = src.physIn[3:0];
  wire logic t = scanTick && {cfg[0].gateInFirst, cfg[0].gateInSecond, cfg[0].gateInThird,
    cfg[0].gateInFourth} == 32'h0001_0203;
  slg_kind_t k;
  assign k = cfg[0].kind;
  logic [3:0] lastX_ff;
  logic       histOk_ff;
  // slot 0 history, trusted only while its operands stay direct
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lastX_ff  <= 4'h0;
      histOk_ff <= 1'h1;
    end else if (scanTick) begin
      lastX_ff  <= x;
      histOk_ff <= t;
    end
  end
  AST_DONE: assert property (scanTick |=> scanDone) else $error("no done");
  AST_HOLD: assert property (!scanTick |=> !scanDone && $stable(gateResult)
    && $stable({extOutputs, baseOutputs})) else $error("changed without tick");
  AST_AND: assert property (t && k == SLG_AND |=> gateResult[0] == &$past(x)) else $error("and");
  AST_OR: assert property (t && k == SLG_OR |=> gateResult[0] == |$past(x)) else $error("or");
  AST_NOT: assert property (t && k == SLG_NOT |=> gateResult[0] != $past(x[0])) else $error("not");
  AST_XOR: assert property (t && k == SLG_XOR |=> gateResult[0] == ^$past(x[1:0])) else $error("xor");
  AST_NAND: assert property (t && k == SLG_NAND |=> gateResult[0] != &$past(x)) else $error("nand");
  AST_NOR: assert property (t && k == SLG_NOR |=> gateResult[0] != |$past(x)) else $error("nor");
  AST_EAND: assert property (t && histOk_ff && k == SLG_AND_EDGE |=>
    gateResult[0] == (&$past(x) && !(&$past(lastX_ff)))) else $error("edge and");
  AST_ENAND: assert property (t && histOk_ff && k == SLG_NAND_EDG |=>
    gateResult[0] == (!(&$past(x)) && &$past(lastX_ff))) else $error("edge nand");
endmodule : slg_gate_bank_asserts
bind slg_gate_bank slg_gate_bank_asserts u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .scanTick(scanTick),
  .src(src), .cfg(cfg), .baseOutputs(baseOutputs), .extOutputs(extOutputs), .gateResult(gateResult),
  .scanDone(scanDone));

/* testbench.sv */
// self-checking testbench for the scan logic gate bank
`timescale 1ns/1ps
`include "slg_defs.svh"
module testbench;
  import slg_pkg::*;
  logic                          clk_sys, rst_n, scanTick, scanDone;
  slg_src_t                      src;
  slg_cfg_t [`SLG_NUM_GATES-1:0] cfg;
  logic [7:0]                    baseOutputs, gateResult;
  logic [23:0]                   extOutputs;
  logic [31:0]                   img;
  logic [7:0][3:0]               prev;
  int                            n_mismatch = 0, cmp_count = 0;
  // design under test
  slg_gate_bank dut (.clk_sys(clk_sys), .rst_n(rst_n), .scanTick(scanTick), .src(src), .cfg(cfg),
    .baseOutputs(baseOutputs), .extOutputs(extOutputs), .gateResult(gateResult), .scanDone(scanDone));
  // free-running clock
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  // reference result of one gate
  function automatic logic ev(input logic [2:0] kd, input logic [3:0] c, input logic [3:0] p);
    case (kd)
      SLG_AND:      return &c;
      SLG_AND_EDGE: return &c && !(&p);
      SLG_OR:       return |c;
      SLG_NOT:      return !c[0];
      SLG_XOR:      return c[0] ^ c[1];
      SLG_NAND:     return !(&c);
      SLG_NAND_EDG: return !(&c) && &p;
      default:      return !(|c);
    endcase
  endfunction : ev
  // one scan period with the done pulse checked
  task automatic tick;
    scanTick <= 1'h1;
    @(posedge clk_sys) scanTick <= 1'h0;
    #1 chk(scanDone, 1);
  endtask : tick
  // all slots of one kind, slot s on inputs 4s..4s+3
  task automatic step(input logic [2:0] kd, input logic [31:0] pin);
    logic r;
    @(posedge clk_sys);
    src.physIn <= {18'h0, pin};
    for (int s = 0; s < 8; s++)
      cfg[s] <= '{slg_kind_t'(kd), 8'(4*s), 8'(4*s+1), 8'(4*s+2), 8'(4*s+3), 1'h1, 5'(s+8*kd[1:0])};
    tick();
    for (int s = 0; s < 8; s++) begin
      r = ev(kd, pin[4*s+:4], prev[s]);
      prev[s] = pin[4*s+:4];
      img[s+8*kd[1:0]] = r;
      chk(gateResult[s], r);
    end
    chk({extOutputs, baseOutputs}, img);
  endtask : step
  // every kind against every operand pattern
  task automatic t_truth;
    logic [31:0] pin;
    for (int kd = 0; kd < 8; kd++)
      for (int v = 0; v < 16; v++) begin
        for (int s = 0; s < 8; s++) pin[4*s+:4] = 4'(v + s);
        step(3'(kd), pin);
      end
  endtask : t_truth
  // special operands on slot 0 with every destination off
  task automatic t_sel(input logic [2:0] kd, input logic [31:0] sl, input logic vk, input logic exp);
    @(posedge clk_sys);
    src <= '{50'h2_0000_0000_0000, {vk, 31'h0}};
    for (int s = 1; s < 8; s++) cfg[s].destEn <= 1'h0;
    cfg[0] <= '{slg_kind_t'(kd), sl[31:24], sl[23:16], sl[15:8], sl[7:0], 1'h0, 5'h0};
    tick();
    chk(gateResult[0], exp);
    chk({extOutputs, baseOutputs}, img);
  endtask : t_sel
  // reset in mid-run clears outputs and history
  task automatic t_reset;
    step(SLG_AND, 32'hFFFF_FFFF);
    @(posedge clk_sys) rst_n <= 1'h0;
    @(posedge clk_sys) #1 chk({extOutputs, baseOutputs}, 0);
    chk({gateResult, scanDone}, 0);
    @(posedge clk_sys) rst_n <= 1'h1;
    prev = '0;
    img = '0;
    step(SLG_NAND_EDG, 32'h0);
    step(SLG_AND_EDGE, 32'hFFFF_FFFF);
  endtask : t_reset
  // main sequence
  initial begin
    rst_n = 1'h0;
    scanTick = 1'h0;
    src = '0;
    cfg = '0;
    img = '0;
    prev = '0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'h1;
    t_truth();
    t_sel(SLG_AND, {`SLG_SEL_HIGH, `SLG_SEL_NOCONN, 8'h5F, 8'h31}, 1'h1, 1'h1);
    t_sel(SLG_AND, {`SLG_SEL_HIGH, `SLG_SEL_NOCONN, 8'h5F, 8'h31}, 1'h0, 1'h0);
    t_sel(SLG_OR, {`SLG_SEL_LOW, `SLG_SEL_NOCONN, 8'h5F, `SLG_SEL_LOW}, 1'h1, 1'h1);
    t_sel(SLG_NOR, {`SLG_SEL_LOW, `SLG_SEL_NOCONN, 8'h5F, `SLG_SEL_LOW}, 1'h0, 1'h1);
    t_sel(SLG_OR, {8'h70, `SLG_SEL_NOCONN, `SLG_SEL_LOW, `SLG_SEL_LOW}, 1'h1, 1'h0);
    t_sel(SLG_AND_EDGE, {`SLG_SEL_NOCONN, `SLG_SEL_NOCONN, `SLG_SEL_NOCONN, `SLG_SEL_HIGH}, 1'h0, 1'h1);
    t_sel(SLG_NAND_EDG, {`SLG_SEL_NOCONN, `SLG_SEL_NOCONN, `SLG_SEL_NOCONN, `SLG_SEL_LOW}, 1'h0, 1'h1);
    t_reset();
    complete_run();
  end
  // watchdog against a hang
  initial begin
    #50000;
    n_mismatch++;
    complete_run();
  end
endmodule : testbench
